//--- rtl/eas_cfg.svh
`ifndef EAS_CFG_SVH
`define EAS_CFG_SVH

// ==========================================================
// Clock
`define CLK_MHZ 50

// ==========================================================
// Programming times in microseconds
`define T_WDSFID_US 6000
`define T_LDSFID_US 6000
`define T_SEAS_US 6000
`define T_REAS_US 6000
`define T_LEAS_US 6000

// ==========================================================
// Opcodes
`define OP_WR_DSFID 8'h29
`define OP_LK_DSFID 8'h2A
`define OP_SET_EAS 8'hA2
`define OP_RST_EAS 8'hA3
`define OP_LK_EAS 8'hA4
`define OP_ACT_EAS 8'hA5

// ==========================================================
// Answer flags and error codes
`define FLAGS_OK 8'h00
`define FLAGS_ERR 8'h01
`define ERR_GENERIC 8'h0F
`define ERR_LOCKED 8'h12
`define ERR_ALREADY 8'h11

// ==========================================================
// Telegram blocks and mask lengths
`define BLK_LAST 8'h1F
`define BLK_CFG00 8'h18
`define BLK_CFG01 8'h1C
`define BLK_CFG10 8'h1E
`define BLK_CFG11 8'h1F
`define MASK_NONE 8'h00
`define MASK_BYTE 8'h08
`define MASK_WORD 8'h10

// ==========================================================
// Delivery values of the non-volatile state
`define RST_TCFG 2'h3
`define RST_DSFID 8'h00
`define RST_EAS_ID 16'h0000
`define RST_UID 64'h0000_0000_0000_0000

// ==========================================================
// Register byte offsets, fields and bus response codes
`define REG_CTRL 8'h00
`define REG_EAS_ID 8'h04
`define REG_UID_LO 8'h08
`define REG_UID_HI 8'h0C
`define REG_STATUS 8'h10
`define CTRL_TCFG_LSB 0
`define CTRL_PROT_BIT 4
`define ST_SET_BIT 0
`define ST_LOCK_BIT 1
`define ST_DLOCK_BIT 2
`define ST_BUSY_BIT 3
`define ST_DSFID_LSB 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/eas_pkg.sv
package eas_pkg;

	// ==========================================================
	// Decoded request from the frame decoder
	typedef struct packed {
		logic [7:0] opcode;
		logic option;
		logic addressed;
		logic secure;
		logic [7:0] mfg;
		logic [63:0] uid;
		logic [7:0] param;
		logic [15:0] id_val;
	} cmd_t;

	// One answer byte to the frame encoder
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} resp_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CHECK,
		ST_PROG,
		ST_WAIT_EOF,
		ST_FETCH,
		ST_LOAD,
		ST_TX
	} state_t;

	// Non-volatile state image
	typedef struct packed {
		logic eas_set;
		logic eas_lock;
		logic eas_prot;
		logic [7:0] dsfid;
		logic dsfid_lock;
		logic [15:0] eas_id;
		logic [1:0] tcfg;
		logic [63:0] uid;
	} nv_t;

endpackage

//--- rtl/eas_dsfid_command_handler.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`include "eas_cfg.svh"

module eas_dsfid_command_handler
	import eas_pkg::*;
#(
	parameter int T_WDSFID_US = `T_WDSFID_US,
	parameter int T_LDSFID_US = `T_LDSFID_US,
	parameter int T_SEAS_US = `T_SEAS_US,
	parameter int T_REAS_US = `T_REAS_US,
	parameter int T_LEAS_US = `T_LEAS_US,
	parameter logic [7:0] MFG_CODE = 8'h5A // Arbitrary value
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire cmd_t cmd,
	input wire logic eof_seen,
	output logic resp_valid,
	input wire logic resp_ready,
	output resp_t resp,
	output logic mem_rd_en,
	output logic [7:0] mem_rd_addr,
	input wire logic [31:0] mem_rd_data,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ==========================================================
	// Programming counts
	localparam logic [31:0] WDSFID_CYC = 32'(T_WDSFID_US * `CLK_MHZ);
	localparam logic [31:0] LDSFID_CYC = 32'(T_LDSFID_US * `CLK_MHZ);
	localparam logic [31:0] SEAS_CYC = 32'(T_SEAS_US * `CLK_MHZ);
	localparam logic [31:0] REAS_CYC = 32'(T_REAS_US * `CLK_MHZ);
	localparam logic [31:0] LEAS_CYC = 32'(T_LEAS_US * `CLK_MHZ);

	// ==========================================================
	// State
	typedef struct packed {
		state_t state;
		cmd_t cmd;
		logic [31:0] timer;
		logic [31:0] buf_d;
		logic [2:0] cnt;
		logic tele;
		logic blk_done;
		logic [7:0] blk;
		nv_t nv;
		logic aw_held;
		logic w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} st_t;

	st_t s_q;
	st_t s_d;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// First telegram block from the length setting
	function automatic logic [7:0] start_blk(input logic [1:0] cfg);
		case (cfg)
			2'h0: return `BLK_CFG00;
			2'h1: return `BLK_CFG01;
			2'h2: return `BLK_CFG10;
			default: return `BLK_CFG11;
		endcase
	endfunction

	// Programming count per opcode
	function automatic logic [31:0] prog_cyc(input logic [7:0] op);
		case (op)
			`OP_WR_DSFID: return WDSFID_CYC;
			`OP_LK_DSFID: return LDSFID_CYC;
			`OP_SET_EAS: return SEAS_CYC;
			`OP_RST_EAS: return REAS_CYC;
			default: return LEAS_CYC;
		endcase
	endfunction

	// ==========================================================
	// Combinational outputs
	assign cmd_ready = (s_q.state == ST_IDLE);
	assign resp_valid = (s_q.state == ST_TX);
	assign resp.data = s_q.buf_d[7:0];
	assign resp.last = (s_q.cnt == 3'h1) && !(s_q.tele && !s_q.blk_done);
	assign mem_rd_en = (s_q.state == ST_FETCH);
	assign mem_rd_addr = s_q.blk;
	assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;

	// Next-state logic
	always_comb
	begin
		logic is_custom;
		logic is_write;
		logic prot_block;
		logic [31:0] ctrl_v;
		logic [31:0] wv;
		is_custom = 1'b0;
		is_write = 1'b0;
		prot_block = 1'b0;
		ctrl_v = '0;
		wv = '0;
		s_d = s_q;

		// ======================================================
		// Command sequencer
		case (s_q.state)
			ST_IDLE:
			begin
				if (cmd_valid)
				begin
					s_d.cmd = cmd;
					s_d.state = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				is_custom = s_q.cmd.opcode[7];
				prot_block = s_q.nv.eas_prot && !s_q.cmd.secure;
				s_d.state = ST_IDLE;
				s_d.tele = 1'b0;
				s_d.blk_done = 1'b1;
				s_d.buf_d = {24'h0, `FLAGS_ERR};
				s_d.cnt = 3'h2;
				if ((is_custom && s_q.cmd.mfg != MFG_CODE)
					|| (s_q.cmd.addressed && s_q.cmd.uid != s_q.nv.uid))
					s_d.state = ST_IDLE;
				else
				begin
					case (s_q.cmd.opcode)
						`OP_WR_DSFID:
						begin
							is_write = !s_q.nv.dsfid_lock;
							s_d.buf_d[15:8] = `ERR_LOCKED;
						end
						`OP_LK_DSFID:
						begin
							is_write = !s_q.nv.dsfid_lock;
							s_d.buf_d[15:8] = `ERR_ALREADY;
						end
						`OP_SET_EAS, `OP_RST_EAS:
						begin
							is_write = !prot_block && !s_q.nv.eas_lock;
							s_d.buf_d[15:8] = prot_block ? `ERR_GENERIC : `ERR_LOCKED;
						end
						`OP_LK_EAS:
						begin
							is_write = !prot_block && !s_q.nv.eas_lock;
							s_d.buf_d[15:8] = prot_block ? `ERR_GENERIC : `ERR_ALREADY;
						end
						`OP_ACT_EAS:
						begin
							// Silent unless state set; errors stay silent
							if (s_q.nv.eas_set)
							begin
								s_d.buf_d = {24'h0, `FLAGS_OK};
								s_d.cnt = 3'h1;
								if (s_q.cmd.option && s_q.cmd.param == `MASK_NONE)
								begin
									s_d.buf_d = {8'h0, s_q.nv.eas_id, `FLAGS_OK};
									s_d.cnt = 3'h3;
									s_d.state = ST_TX;
								end
								else if (!s_q.cmd.option
									|| (s_q.cmd.param == `MASK_BYTE
									&& s_q.cmd.id_val[7:0] == s_q.nv.eas_id[7:0])
									|| (s_q.cmd.param == `MASK_WORD
									&& s_q.cmd.id_val == s_q.nv.eas_id))
								begin
									s_d.tele = 1'b1;
									s_d.blk_done = 1'b0;
									s_d.blk = start_blk(s_q.nv.tcfg);
									s_d.state = ST_TX;
								end
							end
						end
						default: s_d.state = ST_IDLE;
					endcase
					if (s_q.cmd.opcode != `OP_ACT_EAS && s_d.state == ST_IDLE
						&& s_q.cmd.opcode inside {`OP_WR_DSFID, `OP_LK_DSFID,
						`OP_SET_EAS, `OP_RST_EAS, `OP_LK_EAS})
					begin
						if (is_write)
						begin
							s_d.timer = prog_cyc(s_q.cmd.opcode);
							s_d.state = s_q.cmd.option ? ST_WAIT_EOF : ST_PROG;
						end
						else
							s_d.state = ST_TX;
					end
				end
			end
			ST_PROG, ST_WAIT_EOF:
			begin
				if (s_q.state == ST_PROG)
					s_d.timer = s_q.timer - 32'h1;
				// Commit once programming time or reader EOF is over
				if ((s_q.state == ST_PROG && s_q.timer == 32'h1)
					|| (s_q.state == ST_WAIT_EOF && eof_seen))
				begin
					case (s_q.cmd.opcode)
						`OP_WR_DSFID: s_d.nv.dsfid = s_q.cmd.param;
						`OP_LK_DSFID: s_d.nv.dsfid_lock = 1'b1;
						`OP_SET_EAS: s_d.nv.eas_set = 1'b1;
						`OP_RST_EAS: s_d.nv.eas_set = 1'b0;
						default: s_d.nv.eas_lock = 1'b1;
					endcase
					s_d.buf_d = {24'h0, `FLAGS_OK};
					s_d.cnt = 3'h1;
					s_d.state = ST_TX;
				end
			end
			ST_FETCH: s_d.state = ST_LOAD;
			ST_LOAD:
			begin
				s_d.buf_d = mem_rd_data;
				s_d.cnt = 3'h4;
				s_d.blk_done = (s_q.blk == `BLK_LAST);
				s_d.blk = s_q.blk + 8'h1;
				s_d.state = ST_TX;
			end
			ST_TX:
			begin
				if (resp_ready)
				begin
					s_d.buf_d = {8'h0, s_q.buf_d[31:8]};
					s_d.cnt = s_q.cnt - 3'h1;
					if (s_q.cnt == 3'h1)
						s_d.state = (s_q.tele && !s_q.blk_done) ? ST_FETCH : ST_IDLE;
				end
			end
			default: s_d.state = ST_IDLE;
		endcase

		// ======================================================
		// Register bus write side
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_held = 1'b1;
			s_d.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_held = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.aw_held && s_q.w_held)
		begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `RESP_OKAY;
			ctrl_v[`CTRL_TCFG_LSB +: 2] = s_q.nv.tcfg;
			ctrl_v[`CTRL_PROT_BIT] = s_q.nv.eas_prot;
			case (s_q.awaddr)
				`REG_CTRL:
				begin
					wv = merge(ctrl_v, s_q.wdata, s_q.wstrb);
					s_d.nv.tcfg = wv[`CTRL_TCFG_LSB +: 2];
					s_d.nv.eas_prot = wv[`CTRL_PROT_BIT];
				end
				`REG_EAS_ID:
				begin
					wv = merge({16'h0, s_q.nv.eas_id}, s_q.wdata, s_q.wstrb);
					if (!s_q.nv.eas_lock)
						s_d.nv.eas_id = wv[15:0];
				end
				`REG_UID_LO:
				begin
					wv = merge(s_q.nv.uid[31:0], s_q.wdata, s_q.wstrb);
					s_d.nv.uid[31:0] = wv;
				end
				`REG_UID_HI:
				begin
					wv = merge(s_q.nv.uid[63:32], s_q.wdata, s_q.wstrb);
					s_d.nv.uid[63:32] = wv;
				end
				`REG_STATUS: s_d.bresp = `RESP_OKAY;
				default: s_d.bresp = `RESP_SLVERR;
			endcase
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		// ======================================================
		// Register bus read side
		if (s_axi_arvalid && !s_q.rvalid)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `RESP_OKAY;
			s_d.rdata = '0;
			case (s_axi_araddr[7:0])
				`REG_CTRL:
				begin
					s_d.rdata[`CTRL_TCFG_LSB +: 2] = s_q.nv.tcfg;
					s_d.rdata[`CTRL_PROT_BIT] = s_q.nv.eas_prot;
				end
				`REG_EAS_ID: s_d.rdata[15:0] = s_q.nv.eas_id;
				`REG_UID_LO: s_d.rdata = s_q.nv.uid[31:0];
				`REG_UID_HI: s_d.rdata = s_q.nv.uid[63:32];
				`REG_STATUS:
				begin
					s_d.rdata[`ST_SET_BIT] = s_q.nv.eas_set;
					s_d.rdata[`ST_LOCK_BIT] = s_q.nv.eas_lock;
					s_d.rdata[`ST_DLOCK_BIT] = s_q.nv.dsfid_lock;
					s_d.rdata[`ST_BUSY_BIT] = (s_q.state != ST_IDLE);
					s_d.rdata[`ST_DSFID_LSB +: 8] = s_q.nv.dsfid;
				end
				default: s_d.rresp = `RESP_SLVERR;
			endcase
		end
		else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
	end

	// State register; reset loads the delivery image
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			s_q <= '0;
			s_q.state <= ST_IDLE;
			s_q.nv.eas_set <= 1'b0;
			s_q.nv.tcfg <= `RST_TCFG;
			s_q.nv.dsfid <= `RST_DSFID;
			s_q.nv.eas_id <= `RST_EAS_ID;
			s_q.nv.uid <= `RST_UID;
		end
		else
			s_q <= s_d;
	end

endmodule // eas_dsfid_command_handler

//--- tb/eas_chk.sv
// ==========================================================
// Port checker for the command handler
module eas_chk
	import eas_pkg::*;
#(
	parameter logic [7:0] MFG_CODE = 8'h5A, // Arbitrary value
	parameter int T_US = 1
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire cmd_t cmd,
	input wire logic resp_valid,
	input wire logic resp_ready,
	input wire resp_t resp,
	input wire logic mem_rd_en,
	input wire logic [7:0] mem_rd_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = T_US * 50 + 2;
	logic take;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// Request taken at this edge
	assign take = cmd_valid && cmd_ready;
	property p_take_busy;
		take |=> !cmd_ready;
	endproperty
	a_take_busy: assert property (p_take_busy) else $error("ready after take");
	property p_resp_hold;
		resp_valid && !resp_ready |=> resp_valid && $stable(resp);
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("answer byte dropped");
	property p_no_overlap;
		resp_valid |-> !cmd_ready;
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("ready while sending");
	property p_mem_rng;
		mem_rd_en |-> mem_rd_addr >= 8'h18 && mem_rd_addr <= 8'h1F;
	endproperty
	a_mem_rng: assert property (p_mem_rng) else $error("block out of range");
	property p_silent;
		take && cmd.opcode[7] && cmd.mfg != MFG_CODE |=> !resp_valid ##1 (cmd_ready && !resp_valid);
	endproperty
	a_silent: assert property (p_silent) else $error("answer to foreign code");
	property p_wtime;
		take && !cmd.option && cmd.mfg == MFG_CODE && !cmd.addressed
			&& (cmd.opcode inside {8'h29, 8'h2A, 8'hA2, 8'hA3, 8'hA4}) |-> ##[2:W] resp_valid;
	endproperty
	a_wtime: assert property (p_wtime) else $error("write answer late");
	property p_act_quick;
		take && cmd.opcode == 8'hA5 |-> ##2 (cmd_ready ^ resp_valid);
	endproperty
	a_act_quick: assert property (p_act_quick) else $error("active request stuck");
	property p_last_idle;
		resp_valid && resp_ready && resp.last |=> cmd_ready;
	endproperty
	a_last_idle: assert property (p_last_idle) else $error("no idle after last");
endmodule // eas_chk

bind eas_dsfid_command_handler eas_chk #(.MFG_CODE(MFG_CODE), .T_US(T_SEAS_US)) u_chk (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready),
	.cmd(cmd),
	.resp_valid(resp_valid),
	.resp_ready(resp_ready),
	.resp(resp),
	.mem_rd_en(mem_rd_en),
	.mem_rd_addr(mem_rd_addr)
);

//--- tb/reader_model.sv
// ==========================================================
// Reader and user memory on the far side
module reader_model
	import eas_pkg::*;
(
	input wire logic sys_clk,
	output cmd_t cmd,
	output logic cmd_valid,
	input wire logic cmd_ready,
	output logic eof_seen,
	input wire logic resp_valid,
	output logic resp_ready,
	input wire resp_t resp,
	input wire logic mem_rd_en,
	input wire logic [7:0] mem_rd_addr,
	output logic [31:0] mem_rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	logic slow = 1'h0;
	// Idle levels at time zero
	initial
	begin
		cmd = '0;
		cmd_valid = 1'h0;
		eof_seen = 1'h0;
		resp_ready = 1'h0;
		mem_rd_data = 32'h0;
	end
	// Sync memory, scrambled when not read
	always @(posedge sys_clk)
		mem_rd_data <= mem_rd_en ? {mem_rd_addr, 8'h5C, mem_rd_addr, 8'hC3} : ~mem_rd_data;
	// Collect answer bytes, stall every other cycle when slow
	always @(posedge sys_clk)
	begin
		if (resp_valid && resp_ready)
			got.push_back(resp.data);
		resp_ready <= !slow || !resp_ready;
	end
	// Hold frame with code byte and id until taken
	task send(input cmd_t c);
		@(posedge sys_clk);
		cmd <= c;
		cmd_valid <= 1'h1;
		do
			@(posedge sys_clk);
		while (!cmd_ready);
		cmd_valid <= 1'h0;
		cmd <= ~c;
	endtask
	// End of frame, a one-cycle pulse of eof_seen when called
	task eof;
		eof_seen <= 1'h1;
		@(posedge sys_clk);
		eof_seen <= 1'h0;
	endtask
endmodule // reader_model

//--- tb/eas_dsfid_command_handler_tb_top.sv
// ==========================================================
// Testbench for the command handler
module eas_dsfid_command_handler_tb_top
	import eas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic cmd_valid, cmd_ready, eof_seen, resp_valid, resp_ready, mem_rd_en;
	cmd_t cmd;
	cmd_t c;
	resp_t resp;
	logic [7:0] mem_rd_addr;
	logic [31:0] mem_rd_data, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
	logic [7:0] exp[$];
	int n_fail = 0;
	int num_checks = 0;
	eas_dsfid_command_handler #(.T_WDSFID_US(1), .T_LDSFID_US(1), .T_SEAS_US(1),
		.T_REAS_US(1), .T_LEAS_US(1)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .eof_seen(eof_seen), .resp_valid(resp_valid), .resp_ready(resp_ready),
		.resp(resp), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
		.mem_rd_data(mem_rd_data), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);
	reader_model u_rdr (
		.sys_clk(sys_clk), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.eof_seen(eof_seen), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp),
		.mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data)
	);
	// Clock
	initial
		forever #10 sys_clk = ~sys_clk;
	// Compare and count
	task chk(input logic [31:0] got, want);
		num_checks++;
		if (got !== want)
		begin
			n_fail++;
			$display("ERROR %0t got %h want %h", $time, got, want);
		end
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Register write, address and data offered together
	task wr(input logic [31:0] a, d, input logic [3:0] st);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		rb = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// Register read
	task rd(input logic [31:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// Build request, bit 0 option, bit 1 secure
	function automatic cmd_t mk(input logic [7:0] op, input logic [1:0] os,
		input logic [7:0] p, input logic [15:0] id);
		cmd_t r;
		r = '0;
		r.opcode = op;
		r.option = os[0];
		r.secure = os[1];
		r.mfg = 8'h5A;
		r.param = p;
		r.id_val = id;
		return r;
	endfunction
	// Expect flags, then blocks s to 31 ascending, low byte first
	task tel(input logic [7:0] s);
		exp.push_back(8'h00);
		for (int b = s; b <= 31; b++)
		begin
			exp.push_back(8'hC3);
			exp.push_back(b[7:0]);
			exp.push_back(8'h5C);
			exp.push_back(b[7:0]);
		end
	endtask
	// One request; d nonzero sends end of frame after d cycles
	task run(input cmd_t q, input int d);
		int i;
		u_rdr.got.delete();
		u_rdr.send(q);
		if (d > 0)
		begin
			repeat (d) @(posedge sys_clk);
			chk(u_rdr.got.size(), 0);
			u_rdr.eof();
		end
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end while (!cmd_ready && i < 400);
		chk(cmd_ready, 1'h1);
		chk(u_rdr.got.size(), exp.size());
		foreach (exp[k])
			chk(u_rdr.got[k], exp[k]);
		exp.delete();
	endtask
	// Main sequence
	initial
	begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'h0;
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rd(32'h10);
		chk(rv, 32'h0);
		rd(32'h0);
		chk(rv, 32'h3);
		chk(rr, 2'h0);
		rd(32'h20);
		chk(rr, 2'h2);
		chk(rv, 32'h0);
		wr(32'h20, 32'h0, 4'hF);
		chk(rb, 2'h2);
		run(mk(8'hA5, 2'h0, 8'h00, 16'h0000), 0);
		exp = '{8'h00};
		run(mk(8'hA2, 2'h0, 8'h00, 16'h0000), 0);
		for (int t = 0; t < 4; t++)
		begin
			u_rdr.slow = t[0];
			wr(32'h0, 32'(t), 4'hF);
			chk(rb, 2'h0);
			tel(8'h20 - (8'h08 >> t));
			run(mk(8'hA5, 2'h0, 8'h00, 16'h0000), 0);
		end
		wr(32'h4, 32'h0000_1299, 4'hF);
		wr(32'h4, 32'h5555_AA34, 4'h1);
		exp = '{8'h00, 8'h34, 8'h12};
		run(mk(8'hA5, 2'h1, 8'h00, 16'h0000), 0);
		tel(8'h1F);
		run(mk(8'hA5, 2'h1, 8'h08, 16'hAA34), 0);
		run(mk(8'hA5, 2'h1, 8'h10, 16'h1235), 0);
		c = mk(8'hA2, 2'h0, 8'h00, 16'h0000);
		c.mfg = 8'hA5;
		run(c, 0);
		c = mk(8'hA3, 2'h0, 8'h00, 16'h0000);
		c.addressed = 1'h1;
		c.uid = 64'h1;
		run(c, 0);
		wr(32'h0, 32'h13, 4'hF);
		exp = '{8'h01, 8'h0F};
		run(mk(8'hA3, 2'h0, 8'h00, 16'h0000), 0);
		exp = '{8'h00};
		run(mk(8'hA3, 2'h3, 8'h00, 16'h0000), 60);
		rd(32'h10);
		chk(rv[0], 1'h0);
		exp = '{8'h00};
		run(mk(8'hA2, 2'h2, 8'h00, 16'h0000), 0);
		exp = '{8'h00};
		run(mk(8'hA4, 2'h2, 8'h00, 16'h0000), 0);
		exp = '{8'h01, 8'h12};
		run(mk(8'hA3, 2'h2, 8'h00, 16'h0000), 0);
		exp = '{8'h01, 8'h12};
		run(mk(8'hA2, 2'h2, 8'h00, 16'h0000), 0);
		wr(32'h4, 32'h5555, 4'hF);
		rd(32'h4);
		chk(rv[15:0], 16'h1234);
		rd(32'h10);
		chk(rv[1:0], 2'h3);
		exp = '{8'h00};
		run(mk(8'h29, 2'h0, 8'h7E, 16'h0000), 0);
		rd(32'h10);
		chk(rv[15:8], 8'h7E);
		exp = '{8'h00};
		run(mk(8'h2A, 2'h1, 8'h00, 16'h0000), 60);
		exp = '{8'h01, 8'h11};
		run(mk(8'h2A, 2'h0, 8'h00, 16'h0000), 0);
		print_verdict();
	end
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		print_verdict();
	end
endmodule // eas_dsfid_command_handler_tb_top
